/* File: cict_core_timing.sv */
// Instruction fetch and cycle timing sequencer
// How it works
// RULE1: one instruction cycle equals one core clock
// RULE2: register add forms: one byte, one cycle
// RULE3: indirect add forms: one byte, two cycles
// RULE4: direct/immediate add forms: two bytes, two cycles
// RULE5: indirect increment/decrement: one byte, two cycles
// RULE6: direct increment/decrement: two bytes, two cycles
// RULE7: data pointer increment: one byte, three cycles
// RULE8: register logic ops: one byte, one cycle
// RULE9: indirect and/or: one byte, two cycles
// RULE10: indirect xor taken as two bytes, two cycles
// RULE11: direct/immediate logic ops: two bytes, two cycles
// RULE12: and/or immediate to direct: three bytes, three
// RULE13: external moves take four plus wait states
// RULE14: fetch operands, retire, then fetch next
`timescale 1ns/10ps
module cict_core_timing (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_code_byte,
	input  wire logic [2:0]  i_wait_states,
	output logic      [15:0] o_code_addr,
	output logic      [7:0]  o_opcode,
	output logic      [7:0]  o_operand1,
	output logic      [7:0]  o_operand2,
	output logic      [1:0]  o_ins_len,
	output logic      [3:0]  o_ins_cycles,
	output logic             o_known,
	output logic             o_ext_move_busy,
	output logic             o_retire
);
	typedef struct packed {
		cict_pkg::cict_state_t state;
		logic [15:0]           pc;
		logic [3:0]            cyc_left;
		logic [1:0]            bytes_left;
		logic                  second;
		logic [7:0]            opcode;
		logic [7:0]            operand1;
		logic [7:0]            operand2;
		logic [1:0]            len;
		logic [3:0]            cycles;
		logic                  known;
		logic                  ext_busy;
		logic                  retire;
	} cict_seq_t;

	cict_seq_t  seq_reg;
	cict_seq_t  seq_next;
	logic [1:0] dec_len;
	logic [3:0] dec_cycles;
	logic       dec_known;
	logic       dec_ext;

	cict_decode u_decode (
		.i_opcode      (i_code_byte),
		.i_wait_states (i_wait_states),
		.o_len         (dec_len),
		.o_cycles      (dec_cycles),
		.o_known       (dec_known),
		.o_ext_move    (dec_ext)
	);

	always_comb begin
		seq_next        = seq_reg;
		seq_next.retire = 1'b0;
		case (seq_reg.state)
			cict_pkg::ST_FETCH: begin
				// Opcode byte at current address
				seq_next.opcode     = i_code_byte;
				seq_next.operand1   = 8'h00;
				seq_next.operand2   = 8'h00;
				seq_next.len        = dec_len;
				seq_next.cycles     = dec_cycles;
				seq_next.known      = dec_known;
				seq_next.pc         = seq_reg.pc + 16'h0001;
				seq_next.bytes_left = dec_len - 2'h1;
				seq_next.cyc_left   = dec_cycles - 4'h1; // RULE1
				seq_next.second     = 1'b0;
				if (dec_cycles == cict_pkg::CYC_ONE) begin
					seq_next.retire   = 1'b1; // RULE14
					seq_next.ext_busy = 1'b0;
				end else begin
					seq_next.state    = cict_pkg::ST_EXEC;
					seq_next.ext_busy = dec_ext;
				end
			end
			cict_pkg::ST_EXEC: begin
				if (seq_reg.bytes_left != 2'h0) begin
					// Operand bytes fetched one per cycle
					if (seq_reg.second) begin
						seq_next.operand2 = i_code_byte; // RULE14
					end else begin
						seq_next.operand1 = i_code_byte;
					end
					seq_next.second     = 1'b1;
					seq_next.pc         = seq_reg.pc + 16'h0001;
					seq_next.bytes_left = seq_reg.bytes_left - 2'h1;
				end
				seq_next.cyc_left = seq_reg.cyc_left - 4'h1; // RULE1
				if (seq_reg.cyc_left == 4'h1) begin
					seq_next.state    = cict_pkg::ST_FETCH; // RULE14
					seq_next.retire   = 1'b1;
					seq_next.ext_busy = 1'b0;
				end
			end
			default: begin
				seq_next.state = cict_pkg::ST_FETCH;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			seq_reg          <= '0;
			seq_reg.state    <= cict_pkg::ST_FETCH;
			seq_reg.pc       <= cict_pkg::PC_RESET;
		end else begin
			seq_reg <= seq_next;
		end
	end

	assign o_code_addr     = seq_reg.pc;
	assign o_opcode        = seq_reg.opcode;
	assign o_operand1      = seq_reg.operand1;
	assign o_operand2      = seq_reg.operand2;
	assign o_ins_len       = seq_reg.len;
	assign o_ins_cycles    = seq_reg.cycles;
	assign o_known         = seq_reg.known;
	assign o_ext_move_busy = seq_reg.ext_busy;
	assign o_retire        = seq_reg.retire;
endmodule : cict_core_timing

/* File: cict_pkg.sv */
// Package: instruction length and cycle constants for the timing sequencer
package cict_pkg;

	localparam int          CODE_AW         = 16;
	localparam logic [1:0]  LEN_ONE         = 2'h1;
	localparam logic [1:0]  LEN_TWO         = 2'h2;
	localparam logic [1:0]  LEN_THREE       = 2'h3;
	localparam logic [3:0]  CYC_ONE         = 4'h1;
	localparam logic [3:0]  CYC_TWO         = 4'h2;
	localparam logic [3:0]  CYC_THREE       = 4'h3;
	localparam logic [3:0]  CYC_EXT_MOVE    = 4'h4;
	// Exclusive-OR indirect is printed as two bytes
	localparam logic [1:0]  LEN_XOR_IND     = 2'h2;

	// Opcode high nibbles
	localparam logic [3:0]  HI_INC          = 4'h0;
	localparam logic [3:0]  HI_DEC          = 4'h1;
	localparam logic [3:0]  HI_ADD          = 4'h2;
	localparam logic [3:0]  HI_ADD_WITH_CARRY_OP = 4'h3;
	localparam logic [3:0]  HI_LOGICAL_OR_OP  = 4'h4;
	localparam logic [3:0]  HI_LOGICAL_AND_OP = 4'h5;
	localparam logic [3:0]  HI_LOGICAL_XOR_OP = 4'h6;
	localparam logic [3:0]  HI_SUBTRACT_WITH_BORROW_OP = 4'h9;
	localparam logic [3:0]  HI_EXT_READ     = 4'hE;
	localparam logic [3:0]  HI_EXT_WRITE    = 4'hF;

	// Opcode low nibbles and the full data pointer increment opcode
	localparam logic [3:0]  LO_DIR_ACC      = 4'h2;
	localparam logic [3:0]  LO_DIR_IMM      = 4'h3;
	localparam logic [3:0]  LO_IMM          = 4'h4;
	localparam logic [3:0]  LO_DIR          = 4'h5;
	localparam logic [3:0]  LO_IND0         = 4'h6;
	localparam logic [3:0]  LO_IND1         = 4'h7;
	localparam logic [3:0]  LO_EXT_DPTR16   = 4'h0;
	localparam logic [3:0]  LO_EXT_IND0     = 4'h2;
	localparam logic [3:0]  LO_EXT_IND1     = 4'h3;
	localparam logic [7:0]  OP_INC_DATA_POINTER_16 = 8'hA3;

	localparam logic [15:0] PC_RESET        = 16'h0000;

	typedef enum logic [0:0] {
		ST_FETCH = 1'b0,
		ST_EXEC  = 1'b1
	} cict_state_t;

endpackage : cict_pkg

/* File: cict_decode.sv */
// Opcode decoder giving byte length and cycle count
`timescale 1ns/10ps
module cict_decode (
	input  wire logic [7:0] i_opcode,
	input  wire logic [2:0] i_wait_states,
	output logic      [1:0] o_len,
	output logic      [3:0] o_cycles,
	output logic            o_known,
	output logic            o_ext_move
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic       arith;
	logic       logic_grp;
	logic       incdec;

	always_comb begin
		hi        = i_opcode[7:4];
		lo        = i_opcode[3:0];
		arith     = (hi == cict_pkg::HI_ADD) || (hi == cict_pkg::HI_ADD_WITH_CARRY_OP) ||
		            (hi == cict_pkg::HI_SUBTRACT_WITH_BORROW_OP);
		logic_grp = (hi == cict_pkg::HI_LOGICAL_OR_OP) || (hi == cict_pkg::HI_LOGICAL_AND_OP) ||
		            (hi == cict_pkg::HI_LOGICAL_XOR_OP);
		incdec    = (hi == cict_pkg::HI_INC) || (hi == cict_pkg::HI_DEC);
		o_len      = cict_pkg::LEN_ONE;
		o_cycles   = cict_pkg::CYC_ONE;
		o_known    = 1'b0;
		o_ext_move = 1'b0;
		if (i_opcode == cict_pkg::OP_INC_DATA_POINTER_16) begin
			o_cycles = cict_pkg::CYC_THREE; // RULE7
			o_known  = 1'b1;
		end else if (((hi == cict_pkg::HI_EXT_READ) || (hi == cict_pkg::HI_EXT_WRITE)) &&
		             ((lo == cict_pkg::LO_EXT_DPTR16) || (lo == cict_pkg::LO_EXT_IND0) ||
		              (lo == cict_pkg::LO_EXT_IND1))) begin
			o_cycles   = cict_pkg::CYC_EXT_MOVE + {1'b0, i_wait_states}; // RULE13
			o_known    = 1'b1;
			o_ext_move = 1'b1;
		end else if ((arith || logic_grp || incdec) && lo[3]) begin
			o_known = 1'b1; // RULE2 RULE8
		end else if ((arith || logic_grp || incdec) && ((lo == cict_pkg::LO_IND0) || (lo == cict_pkg::LO_IND1))) begin
			o_cycles = cict_pkg::CYC_TWO; // RULE3 RULE5 RULE9
			o_known  = 1'b1;
			if (hi == cict_pkg::HI_LOGICAL_XOR_OP) begin
				o_len = cict_pkg::LEN_XOR_IND; // RULE10
			end
		end else if ((arith || logic_grp || incdec) && (lo == cict_pkg::LO_DIR)) begin
			o_len    = cict_pkg::LEN_TWO; // RULE4 RULE6 RULE11
			o_cycles = cict_pkg::CYC_TWO;
			o_known  = 1'b1;
		end else if ((arith || logic_grp) && (lo == cict_pkg::LO_IMM)) begin
			o_len    = cict_pkg::LEN_TWO; // RULE4 RULE11
			o_cycles = cict_pkg::CYC_TWO;
			o_known  = 1'b1;
		end else if (logic_grp && (lo == cict_pkg::LO_DIR_ACC)) begin
			o_len    = cict_pkg::LEN_TWO; // RULE11
			o_cycles = cict_pkg::CYC_TWO;
			o_known  = 1'b1;
		end else if (logic_grp && (lo == cict_pkg::LO_DIR_IMM)) begin
			o_len    = cict_pkg::LEN_THREE; // RULE12
			o_cycles = cict_pkg::CYC_THREE;
			o_known  = 1'b1;
		end
	end
endmodule : cict_decode

/* File: cict_core_timing_chk.sv */
// Timing checker for the cycle sequencer
`timescale 1ns/10ps
module cict_core_timing_chk (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic [7:0]  i_code_byte,
	input wire logic [2:0]  i_wait_states,
	input wire logic [15:0] o_code_addr,
	input wire logic [7:0]  o_opcode,
	input wire logic [7:0]  o_operand1,
	input wire logic [7:0]  o_operand2,
	input wire logic [1:0]  o_ins_len,
	input wire logic [3:0]  o_ins_cycles,
	input wire logic        o_known,
	input wire logic        o_ext_move_busy,
	input wire logic        o_retire
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	wire logic [3:0] hi = i_code_byte[7:4];
	wire logic [3:0] lo = i_code_byte[3:0];
	wire logic ar = hi inside {4'h2, 4'h3, 4'h9};
	wire logic lg = hi inside {4'h4, 4'h5, 4'h6};
	wire logic reg_op = (ar || lg) && i_code_byte[3];
	wire logic ind_op = (ar || hi inside {4'h0, 4'h1, 4'h4, 4'h5}) && lo inside {4'h6, 4'h7};
	wire logic dir_op = (ar && lo inside {4'h4, 4'h5}) || (hi < 4'h2 && lo == 4'h5)
		|| (lg && lo inside {4'h2, 4'h4, 4'h5}) || i_code_byte inside {8'h66, 8'h67};
	wire logic ext_op = hi[3:1] == 3'h7 && lo inside {4'h0, 4'h2, 4'h3};
	wire logic f = o_retire;
	a_reg_ops: assert property (f && reg_op |=> f && o_ins_len == 2'h1)
		else $error("register form timing wrong");
	a_ind_ops: assert property (f && ind_op |=> !f ##1 f && o_ins_len == 2'h1)
		else $error("indirect form timing wrong");
	a_dir_ops: assert property (f && dir_op |=> !f ##1 f && o_ins_len == 2'h2)
		else $error("direct form timing wrong");
	a_data_pointer_16_inc: assert property (f && i_code_byte == 8'hA3 |=> !f[*2] ##1 f && o_ins_len == 2'h1)
		else $error("pointer increment timing wrong");
	a_dir_imm: assert property (f && lo == 4'h3 && lg |=> !f[*2] ##1 f && o_ins_len == 2'h3)
		else $error("direct immediate timing wrong");
	a_ext_busy: assert property (f && ext_op |=> o_ext_move_busy[*3])
		else $error("external move busy missing");
	a_ext_count: assert property (f && ext_op |=> o_ins_cycles == 4'h4 + {1'b0, $past(i_wait_states)})
		else $error("external move count wrong");
	a_addr_step: assert property (f |=> o_code_addr == $past(o_code_addr) + 16'h1)
		else $error("opcode fetch did not advance");
	c_ext: cover property (f && ext_op);
	c_data_pointer_16: cover property (f && i_code_byte == 8'hA3);
	c_tri: cover property (f && lo == 4'h3 && lg);
endmodule : cict_core_timing_chk
bind cict_core_timing cict_core_timing_chk u_chk (.i_ref_clk, .i_rst, .i_code_byte, .i_wait_states, .o_code_addr,
	.o_opcode, .o_operand1, .o_operand2, .o_ins_len, .o_ins_cycles, .o_known, .o_ext_move_busy, .o_retire);

/* File: core_instruction_cycle_timing_test.sv */
// Self-checking bench for the cycle sequencer
`timescale 1ns/10ps
module core_instruction_cycle_timing_test;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] i_wait_states = 3'h0;
	logic [7:0] mem [0:255];
	logic [15:0] pc;
	int err_total = 0;
	int comparisons = 0;
	wire logic [15:0] o_code_addr;
	wire logic [7:0] o_opcode, o_operand1, o_operand2, i_code_byte;
	wire logic [1:0] o_ins_len;
	wire logic o_retire, o_known;
	assign i_code_byte = mem[o_code_addr[7:0]];
	`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
		$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
	cict_core_timing dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_code_byte(i_code_byte),
		.i_wait_states(i_wait_states), .o_code_addr(o_code_addr), .o_opcode(o_opcode), .o_operand1(o_operand1),
		.o_operand2(o_operand2), .o_ins_len(o_ins_len), .o_ins_cycles(), .o_known(o_known), .o_ext_move_busy(),
		.o_retire(o_retire));
	initial begin
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic expect_ins(input logic [7:0] op, input logic [1:0] len, input int cyc);
		int n;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end while (o_retire !== 1'b1 && n < 20);
		pc = pc + 16'(len);
		`CHK(n, cyc)
		`CHK(o_opcode, op)
		`CHK(o_ins_len, len)
		`CHK(o_code_addr, pc)
		`CHK(o_known, (op != 8'hA4))
		if (len > 2'h1) `CHK(o_operand1, ~op)
		if (len > 2'h2) `CHK(o_operand2, op ^ 8'h0F)
		else `CHK(o_operand2, 8'h00)
		if (n >= 20) print_verdict();
	endtask : expect_ins
	task automatic run_list(input logic [7:0] op[$], input logic [1:0] ln[$], input int cy[$], input logic [2:0] n);
		int w;
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		i_wait_states <= n;
		w = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		foreach (op[i]) begin
			mem[w] = op[i];
			mem[w + 1] = ~op[i];
			mem[w + 2] = op[i] ^ 8'h0F;
			w = w + int'(ln[i]);
		end
		repeat (16) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		pc = 16'h0000;
		foreach (op[i]) expect_ins(op[i], ln[i], cy[i]);
	endtask : run_list
	task automatic arith_group();
		run_list('{8'h28, 8'h36, 8'h94, 8'h25, 8'h05, 8'h16, 8'hA3, 8'h97, 8'h3C},
			'{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1}, '{1, 2, 2, 2, 2, 2, 3, 2, 1}, 3'h0);
	endtask : arith_group
	task automatic logic_group();
		run_list('{8'h58, 8'h46, 8'h66, 8'h62, 8'h44, 8'h53, 8'h43, 8'h68, 8'h57},
			'{2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h1}, '{1, 2, 2, 2, 2, 3, 3, 1, 2}, 3'h0);
	endtask : logic_group
	task automatic ext_moves();
		run_list('{8'hE0, 8'hF2, 8'hA4, 8'h28}, '{2'h1, 2'h1, 2'h1, 2'h1}, '{4, 4, 1, 1}, 3'h0);
		run_list('{8'hE3, 8'hF0, 8'hE2}, '{2'h1, 2'h1, 2'h1}, '{11, 11, 11}, 3'h7);
	endtask : ext_moves
	initial begin
		arith_group();
		logic_group();
		ext_moves();
		print_verdict();
	end
endmodule : core_instruction_cycle_timing_test
